// ### inc/oss_pkg.sv
// Constants, enumerations and carriers for the output step sequencer.
// Assumes a single 250 MHz system clock shared by all users.
package oss_pkg;

    // ***********************************
    // Widths and timing
    // ***********************************
    localparam int STEP_N = 16;
    localparam int STEP_W = 4;
    localparam int FREQ_W = 24;
    localparam int VOLT_W = 16;
    localparam int PHASE_W = 12;
    localparam int WAVE_W = 3;
    localparam int CNT_W = 14;
    localparam int DUR_W = 16;
    localparam int TRIGW_W = 16;
    localparam int ELAP_W = 26;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam logic [ELAP_W-1:0] TICKS_PER_S = 26'h00003e8;
    localparam logic [CNT_W-1:0] LOOP_MAX = 14'h270f;
    localparam logic [CNT_W-1:0] LOOP_ENDLESS = 14'h0000;
    localparam logic [STEP_W-1:0] STANDBY_STEP = 4'h0;
    localparam logic [STEP_W-1:0] FIRST_STEP = 4'h1;

    // ***********************************
    // Enumerations
    // ***********************************
    typedef enum logic [1:0] {OSS_FIXED, OSS_CARRY, OSS_RAMP} oss_beh_t;
    typedef enum logic [1:0] {OSS_ADVANCE, OSS_FINISH, OSS_PAUSE} oss_end_t;

    // ***********************************
    // Carriers
    // ***********************************
    typedef struct packed {
        logic [FREQ_W-1:0] freq;
        logic [VOLT_W-1:0] acv;
        logic signed [VOLT_W-1:0] dcv;
    } oss_level_t;

    typedef struct packed {
        logic [DUR_W-1:0] duration;
        oss_level_t level;
        oss_beh_t beh_freq;
        oss_beh_t beh_acv;
        oss_beh_t beh_dcv;
        logic [WAVE_W-1:0] wave;
        logic entry_phase_en;
        logic [PHASE_W-1:0] entry_phase_angle;
        logic exit_phase_en;
        logic [PHASE_W-1:0] exit_phase_angle;
        logic loop_en;
        logic [STEP_W-1:0] loop_target_step;
        logic [CNT_W-1:0] loop_total;
        logic [STEP_W-1:0] first_redirect_dest;
        logic [STEP_W-1:0] second_redirect_dest;
        oss_end_t end_action;
        logic [1:0] sync_code;
        logic trig_en;
    } oss_step_t;

    typedef struct packed {
        oss_level_t level;
        logic [WAVE_W-1:0] wave;
        logic phase_load;
        logic [PHASE_W-1:0] phase;
    } oss_gen_t;

endpackage : oss_pkg

// ### core/oss_sequencer.sv
// Output step sequencer: walks a programmed list of steps and drives the
// waveform generator settings, sync code and step trigger.
// Assumes command pins are asynchronous; generator phase is on clk.
// ***********************************
// ***********************************
module oss_sequencer #(
    parameter int TICK_CYCLES = oss_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic prog_we,
    input wire logic [oss_pkg::STEP_W-1:0] prog_addr,
    input wire oss_pkg::oss_step_t prog_data,
    input wire logic unit_seconds,
    input wire logic dc_mode,
    input wire logic trig_polarity,
    input wire logic [oss_pkg::TRIGW_W-1:0] trig_width,
    input wire logic start_pin,
    input wire logic stop_pin,
    input wire logic resume_pin,
    input wire logic first_redirect_input,
    input wire logic second_redirect_input,
    input wire logic [oss_pkg::PHASE_W-1:0] gen_phase,
    output oss_pkg::oss_gen_t gen_out,
    output logic [1:0] sync_code,
    output logic trig_out,
    output logic running,
    output logic holding,
    output logic [oss_pkg::STEP_W-1:0] step_no
);

    // ***********************************
    // Functions
    // ***********************************
    function automatic logic signed [31:0] ramp(input logic signed [31:0] a,
            input logic signed [31:0] b, input logic [oss_pkg::ELAP_W-1:0] e,
            input logic [oss_pkg::ELAP_W-1:0] d);
        logic signed [63:0] p;
        p = 64'(b) - 64'(a);
        if (d == '0 || e >= d) begin
            return b;
        end
        p = (p * $signed({38'h0, e})) / $signed({38'h0, d});
        return a + 32'(p);
    endfunction : ramp

    function automatic logic signed [31:0] pick(input oss_pkg::oss_beh_t b,
            input logic signed [31:0] s, input logic signed [31:0] t,
            input logic [oss_pkg::ELAP_W-1:0] e, input logic [oss_pkg::ELAP_W-1:0] d);
        unique case (b)
            oss_pkg::OSS_CARRY: return s;
            oss_pkg::OSS_RAMP: return ramp(s, t, e, d);
            default: return t;
        endcase
    endfunction : pick

    function automatic logic crossed(input logic [oss_pkg::PHASE_W-1:0] p,
            input logic [oss_pkg::PHASE_W-1:0] c, input logic [oss_pkg::PHASE_W-1:0] t);
        if (c >= p) begin
            return (t > p) && (t <= c);
        end
        return (t > p) || (t <= c);
    endfunction : crossed

    // ***********************************
    // Storage and state
    // ***********************************
    typedef enum {S_IDLE, S_RUN, S_EXIT, S_HOLD} oss_state_t;

    oss_pkg::oss_step_t steps [oss_pkg::STEP_N];
    logic [oss_pkg::CNT_W-1:0] jumps_q [oss_pkg::STEP_N];
    oss_state_t state_q;
    logic [oss_pkg::STEP_W-1:0] step_q;
    oss_pkg::oss_step_t cur;
    oss_pkg::oss_level_t start_q;
    logic [oss_pkg::ELAP_W-1:0] elapsed_q;
    logic [oss_pkg::ELAP_W-1:0] total;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;
    logic [4:0] cmd;
    logic [oss_pkg::PHASE_W-1:0] phase_prev_q;
    logic [oss_pkg::TRIGW_W-1:0] trig_cnt_q;
    logic enter;
    logic [oss_pkg::STEP_W-1:0] enter_step;
    logic returning_q;
    logic done;
    logic at_phase;
    logic do_jump;
    logic [oss_pkg::STEP_W-1:0] after_step;
    oss_pkg::oss_step_t nxt;
    oss_pkg::oss_level_t lvl_now;

    assign cur = steps[step_q];
    assign nxt = steps[enter_step];
    assign total = unit_seconds ? oss_pkg::ELAP_W'(cur.duration) * oss_pkg::TICKS_PER_S
                                : oss_pkg::ELAP_W'(cur.duration);

    // Level the current step asks for in this cycle; at the final cycle a ramp is on target
    always_comb begin
        lvl_now.freq = oss_pkg::FREQ_W'(pick(cur.beh_freq,
            32'(start_q.freq), 32'(cur.level.freq), elapsed_q, total));
        lvl_now.acv = oss_pkg::VOLT_W'(pick(cur.beh_acv,
            32'(start_q.acv), 32'(cur.level.acv), elapsed_q, total));
        lvl_now.dcv = oss_pkg::VOLT_W'(pick(cur.beh_dcv,
            32'(start_q.dcv), 32'(cur.level.dcv), elapsed_q, total));
    end

    // ***********************************
    // Step table
    // ***********************************
    always_ff @(posedge clk) begin
        if (prog_we) begin
            steps[prog_addr] <= prog_data;
            if (prog_data.loop_total > oss_pkg::LOOP_MAX) begin
                steps[prog_addr].loop_total <= oss_pkg::LOOP_MAX;
            end
            if (prog_addr == oss_pkg::STANDBY_STEP) begin
                steps[prog_addr].loop_en <= 1'b0;
            end
        end
    end

    // ***********************************
    // Command pin synchronisers
    // ***********************************
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {second_redirect_input, first_redirect_input, resume_pin,
                        stop_pin, start_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Rising edges: 0 start, 1 stop, 2 resume, 3 redirect one, 4 redirect two
    assign cmd = sync2_q & ~sync3_q;

    // ***********************************
    // Time base
    // ***********************************
    always_ff @(posedge clk) begin
        if (reset || enter || tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (reset || enter) begin
            elapsed_q <= '0;
        end else if (state_q == S_RUN && tick && elapsed_q < total) begin
            elapsed_q <= elapsed_q + 26'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_prev_q <= '0;
        end else begin
            phase_prev_q <= gen_phase;
        end
    end

    assign done = elapsed_q >= total;
    assign at_phase = crossed(phase_prev_q, gen_phase, cur.exit_phase_angle);

    // ***********************************
    // Step end decision
    // ***********************************
    always_comb begin
        do_jump = cur.loop_en && (cur.loop_total == oss_pkg::LOOP_ENDLESS
                  || jumps_q[step_q] < cur.loop_total);
        if (do_jump) begin
            after_step = cur.loop_target_step;
        end else if (cur.end_action == oss_pkg::OSS_FINISH) begin
            after_step = oss_pkg::STANDBY_STEP;
        end else begin
            after_step = step_q + 4'h1;
        end
    end

    always_comb begin
        enter = 1'b0;
        enter_step = step_q;
        if (cmd[1] && state_q != S_IDLE && !returning_q) begin
            enter = 1'b1;
            enter_step = oss_pkg::STANDBY_STEP;
        end else if (state_q == S_IDLE) begin
            enter = cmd[0];
            enter_step = oss_pkg::FIRST_STEP;
        end else if (!returning_q && (cmd[3] || cmd[4])) begin
            enter = 1'b1;
            enter_step = cmd[3] ? cur.first_redirect_dest : cur.second_redirect_dest;
        end else if (state_q == S_HOLD) begin
            enter = cmd[2];
            enter_step = after_step;
        end else if (!returning_q && cur.end_action != oss_pkg::OSS_PAUSE
                     && ((state_q == S_RUN && done && !(cur.exit_phase_en && !dc_mode))
                     || (state_q == S_EXIT && at_phase))) begin
            enter = 1'b1;
            enter_step = after_step;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || (state_q == S_IDLE && cmd[0])) begin
            for (int i = 0; i < oss_pkg::STEP_N; i++) begin
                jumps_q[i] <= '0;
            end
        end else if (enter && enter_step == after_step && state_q != S_IDLE) begin
            if (do_jump) begin
                jumps_q[step_q] <= jumps_q[step_q] + 14'h1;
            end else begin
                jumps_q[step_q] <= '0;
            end
        end
    end

    // ***********************************
    // Sequencing state
    // ***********************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            step_q <= oss_pkg::STANDBY_STEP;
            returning_q <= 1'b0;
        end else if (enter) begin
            state_q <= S_RUN;
            step_q <= enter_step;
            returning_q <= enter_step == oss_pkg::STANDBY_STEP;
        end else if (state_q == S_RUN && done) begin
            if (returning_q) begin
                state_q <= S_IDLE;
                returning_q <= 1'b0;
            end else if (cur.exit_phase_en && !dc_mode) begin
                state_q <= S_EXIT;
            end else if (cur.end_action == oss_pkg::OSS_PAUSE) begin
                state_q <= S_HOLD;
            end
        end else if (state_q == S_EXIT && at_phase
                     && cur.end_action == oss_pkg::OSS_PAUSE) begin
            state_q <= S_HOLD;
        end
    end

    // ***********************************
    // Generator settings
    // ***********************************
    always_ff @(posedge clk) begin
        if (reset) begin
            start_q <= '0;
        end else if (enter) begin
            start_q <= (state_q == S_RUN) ? lvl_now : gen_out.level;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gen_out <= '0;
        end else begin
            gen_out.phase_load <= 1'b0;
            if (enter) begin
                gen_out.wave <= nxt.wave;
                if (nxt.entry_phase_en && !dc_mode) begin
                    gen_out.phase_load <= 1'b1;
                    gen_out.phase <= nxt.entry_phase_angle;
                end
            end
            if (state_q == S_RUN) begin
                gen_out.level <= lvl_now;
            end
        end
    end

    // ***********************************
    // Connector outputs
    // ***********************************
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_cnt_q <= '0;
        end else if (enter && nxt.trig_en && trig_width != '0) begin
            trig_cnt_q <= trig_width;
        end else if (trig_cnt_q != '0) begin
            trig_cnt_q <= trig_cnt_q - 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync_code <= '0;
            trig_out <= 1'b0;
        end else begin
            sync_code <= (state_q != S_IDLE && !returning_q) ? cur.sync_code : 2'h0;
            trig_out <= (trig_cnt_q != '0) ? trig_polarity : ~trig_polarity;
        end
    end

    assign running = state_q != S_IDLE && !returning_q;
    assign holding = state_q == S_HOLD;
    assign step_no = step_q;

endmodule : oss_sequencer

// ### testbench/oss_sequencer_properties.sv
// Checker: concurrent properties on the step sequencer ports.
// Assumes it is bound to oss_sequencer and command pins stay high 4 cycles.
module oss_sequencer_properties #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic dc_mode,
    input wire logic trig_polarity,
    input wire logic [oss_pkg::TRIGW_W-1:0] trig_width,
    input wire logic start_pin,
    input wire logic stop_pin,
    input wire oss_pkg::oss_gen_t gen_out,
    input wire logic [1:0] sync_code,
    input wire logic trig_out,
    input wire logic running,
    input wire logic holding,
    input wire logic [oss_pkg::STEP_W-1:0] step_no
);
    // ********
    // Helpers
    // ********
    logic [15:0] act_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Length of the current active trigger level
    always_ff @(posedge clk) begin
        if (reset || trig_out != trig_polarity) begin
            act_q <= 16'h0000;
        end else begin
            act_q <= act_q + 16'h0001;
        end
    end

    // ********
    // Properties
    // ********
    a_standby_idle: assert property (
        step_no == oss_pkg::STANDBY_STEP |-> !running && !holding)
        else $error("run flags set in standby step");
    a_start_first_step: assert property (
        $rose(running) |-> step_no == oss_pkg::FIRST_STEP && $past(start_pin, 3))
        else $error("run began without start or not at step one");
    a_stop_to_standby: assert property (
        $rose(stop_pin) && running |-> ##4 step_no == oss_pkg::STANDBY_STEP && !running)
        else $error("stop did not return to step zero");
    a_hold_freeze: assert property (
        holding && $past(holding) |-> $stable(gen_out.level) && $stable(step_no))
        else $error("output moved while holding");
    a_hold_in_run: assert property (
        holding |-> running)
        else $error("hold outside a run");
    a_dc_no_phase: assert property (
        dc_mode && $past(dc_mode) |-> !gen_out.phase_load)
        else $error("phase load in dc mode");
    a_sync_idle: assert property (
        step_no == oss_pkg::STANDBY_STEP && $past(step_no) == oss_pkg::STANDBY_STEP
        |-> sync_code == 2'h0)
        else $error("sync code outside a step");
    a_sync_steady: assert property (
        (running && $stable(step_no))[*3] |-> $stable(sync_code))
        else $error("sync code changed within a step");
    a_trig_width: assert property (
        trig_out == trig_polarity |-> act_q < trig_width)
        else $error("trigger pulse too long");

    c_hold: cover property ($rose(holding));
    c_start: cover property ($rose(running));
    c_trig: cover property (trig_out == trig_polarity);
endmodule : oss_sequencer_properties

// ### testbench/oss_panel.sv
// Panel and control connector model: turns a command request into pin pulses.
// Assumes requests are one-cycle pulses; bits are start, stop, resume, redirect 1, 2.
module oss_panel (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] cmd_req,
    output logic [4:0] pins
);
    logic [2:0] hold_q;

    // Each command level stands four cycles, long enough for the pin synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            pins <= 5'h00;
            hold_q <= 3'h0;
        end else if (cmd_req != 5'h00) begin
            pins <= cmd_req;
            hold_q <= 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
            if (hold_q == 3'h1) begin
                pins <= 5'h00;
            end
        end
    end
endmodule : oss_panel

// ### testbench/tb.sv
// Self-checking bench for the output step sequencer.
// Assumes a 250 MHz clock; the panel model drives the command pins.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [3:0] stp;
        oss_pkg::oss_beh_t beh;
        logic [15:0] dcv;
        logic [15:0] exp;
        logic lvl;
    } oss_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic prog_we = 1'b0;
    logic [3:0] prog_addr = 4'h0;
    oss_pkg::oss_step_t prog_data = '0;
    logic dc_mode = 1'b1;
    logic trig_polarity = 1'b1;
    logic [15:0] trig_width = 16'h0002;
    logic [11:0] gen_phase = 12'h000;
    logic [4:0] cmd_req = 5'h00;
    logic [4:0] pins;
    oss_pkg::oss_gen_t gen_out;
    logic [1:0] sync_code;
    logic trig_out;
    logic running;
    logic holding;
    logic [3:0] step_no;
    oss_pkg::oss_step_t st;
    logic tp;
    int n;
    int k;
    int n_mismatch = 0;
    int checks_done = 0;
    oss_row_t rows [4] = '{'{4'h1, oss_pkg::OSS_FIXED, 16'h0040, 16'h0040, 1'b1},
        '{4'h2, oss_pkg::OSS_RAMP, 16'h0140, 16'h0000, 1'b0},
        '{4'h3, oss_pkg::OSS_CARRY, 16'h7777, 16'h0140, 1'b1},
        '{4'h4, oss_pkg::OSS_FIXED, 16'h0020, 16'h0020, 1'b1}};

    oss_sequencer #(.TICK_CYCLES(4)) i_oss_sequencer (.clk(clk), .reset(reset),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
        .unit_seconds(1'b0), .dc_mode(dc_mode), .trig_polarity(trig_polarity),
        .trig_width(trig_width), .start_pin(pins[0]), .stop_pin(pins[1]),
        .resume_pin(pins[2]), .first_redirect_input(pins[3]),
        .second_redirect_input(pins[4]), .gen_phase(gen_phase), .gen_out(gen_out),
        .sync_code(sync_code), .trig_out(trig_out), .running(running),
        .holding(holding), .step_no(step_no));
    oss_panel i_oss_panel (.clk(clk), .reset(reset), .cmd_req(cmd_req), .pins(pins));

    // ********
    // Clock, phase and tasks
    // ********
    initial forever #2 clk = ~clk;
    always @(negedge clk) gen_phase <= gen_phase + 12'h040;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic prog(input logic [3:0] a, input oss_pkg::oss_step_t s);
        @(negedge clk);
        prog_we = 1'b1;
        prog_addr = a;
        prog_data = s;
        @(negedge clk);
        prog_we = 1'b0;
    endtask : prog

    task automatic go(input logic [4:0] m);
        @(negedge clk);
        cmd_req = m;
        @(negedge clk);
        cmd_req = 5'h00;
    endtask : go

    task automatic wait_step(input logic [3:0] v);
        int i;
        i = 0;
        while (step_no !== v && i < 3000) begin
            @(negedge clk);
            i++;
        end
        chk(step_no, v);
    endtask : wait_step

    function automatic oss_pkg::oss_step_t mk(input logic [15:0] d, input oss_pkg::oss_beh_t b,
        input logic [15:0] v, input oss_pkg::oss_end_t e, input logic [3:0] q);
        oss_pkg::oss_step_t s;
        s = '0;
        s.duration = d;
        s.beh_dcv = b;
        s.level.dcv = v;
        s.end_action = e;
        s.sync_code = q[1:0];
        s.wave = q[2:0];
        s.trig_en = 1'b1;
        s.first_redirect_dest = 4'h3;
        s.second_redirect_dest = 4'h5;
        return s;
    endfunction : mk

    // ********
    // Tests
    // ********
    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        chk(step_no, 4'h0);
        prog(4'h0, mk(16'h0001, oss_pkg::OSS_FIXED, 16'h0000, oss_pkg::OSS_ADVANCE, 4'h0));
        for (k = 0; k < 4; k++) begin
            prog(rows[k].stp, mk(16'h0002, rows[k].beh, rows[k].dcv, rows[k].stp == 4'h4 ?
                oss_pkg::OSS_FINISH : oss_pkg::OSS_ADVANCE, rows[k].stp));
        end
        go(5'h01);
        for (k = 0; k < 4; k++) begin
            wait_step(rows[k].stp);
            repeat (3) @(negedge clk);
            chk(sync_code, rows[k].stp[1:0]);
            chk(gen_out.wave, rows[k].stp[2:0]);
            if (rows[k].lvl) chk(gen_out.level.dcv, rows[k].exp);
        end
        wait_step(4'h0);
        repeat (8) @(negedge clk);
        chk(gen_out.level.dcv, 16'h0000);
        chk(running, 1'b0);
        dc_mode = 1'b0;
        st = mk(16'h0001, oss_pkg::OSS_FIXED, 16'h0010, oss_pkg::OSS_ADVANCE, 4'h1);
        st.loop_en = 1'b1;
        st.loop_target_step = 4'h1;
        st.loop_total = 14'h0002;
        prog(4'h1, st);
        prog(4'h2, mk(16'h0001, oss_pkg::OSS_FIXED, 16'h0000, oss_pkg::OSS_FINISH, 4'h2));
        go(5'h01);
        wait_step(4'h1);
        n = 0;
        tp = 1'b0;
        for (k = 0; k < 300 && step_no !== 4'h2; k++) begin
            @(negedge clk);
            if (trig_out === 1'b1 && tp === 1'b0) n++;
            tp = trig_out;
        end
        chk(n, 3);
        wait_step(4'h0);
        st.end_action = oss_pkg::OSS_PAUSE;
        st.loop_total = 14'h0001;
        prog(4'h1, st);
        go(5'h01);
        wait_step(4'h1);
        repeat (12) @(negedge clk);
        chk(holding, 1'b1);
        go(5'h04);
        repeat (6) @(negedge clk);
        chk({holding, step_no}, 5'h01);
        repeat (10) @(negedge clk);
        chk(holding, 1'b1);
        go(5'h04);
        wait_step(4'h2);
        wait_step(4'h0);
        prog(4'h1, mk(16'h0020, oss_pkg::OSS_FIXED, 16'h0000, oss_pkg::OSS_ADVANCE, 4'h1));
        prog(4'h3, mk(16'h0020, oss_pkg::OSS_FIXED, 16'h0000, oss_pkg::OSS_ADVANCE, 4'h3));
        prog(4'h5, mk(16'h0020, oss_pkg::OSS_FIXED, 16'h0000, oss_pkg::OSS_FINISH, 4'h5));
        go(5'h01);
        wait_step(4'h1);
        go(5'h18);
        repeat (6) @(negedge clk);
        chk(step_no, 4'h3);
        go(5'h10);
        repeat (6) @(negedge clk);
        chk(step_no, 4'h5);
        go(5'h02);
        wait_step(4'h0);
        st = mk(16'h0001, oss_pkg::OSS_FIXED, 16'h0000, oss_pkg::OSS_FINISH, 4'h1);
        st.entry_phase_en = 1'b1;
        st.entry_phase_angle = 12'h123;
        prog(4'h1, st);
        go(5'h01);
        wait_step(4'h1);
        chk(gen_out.phase, 12'h123);
        wait_step(4'h0);
        print_verdict();
    end

    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end
endmodule : tb

bind oss_sequencer oss_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES))
    i_oss_sequencer_properties (.clk(clk), .reset(reset), .dc_mode(dc_mode),
    .trig_polarity(trig_polarity), .trig_width(trig_width), .start_pin(start_pin),
    .stop_pin(stop_pin), .gen_out(gen_out), .sync_code(sync_code), .trig_out(trig_out),
    .running(running), .holding(holding), .step_no(step_no));
